/* File: core/amd_pkg.sv */
// Package with the constants and types of the addressing-mode decoder.
package amd_pkg;

    // Widths of the program counter, data bytes and bit numbers.
    localparam int PC_W = 12;
    localparam int BYTE_W = 8;
    localparam int BIT_SEL_W = 3;

    // Data-space bases of the short-direct window and of the two index registers.
    localparam logic [7:0] SDIR_BASE = 8'h80;
    localparam logic [7:0] IDX_BASE = 8'h80;

    // Opcode field positions.
    localparam int OP_SDIR_LSB = 0;
    localparam int OP_BIT_LSB = 0;
    localparam int OP_POL_BIT = 3;
    localparam int OP_IDX_SEL_BIT = 4;
    localparam int OP_REL_MSB = 4;
    localparam int OP_EXT_MSB = 3;

    // Instruction lengths in bytes.
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    // Reset values of the held state.
    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Addressing modes that the core's opcode decode hands over.
    typedef enum logic [2:0] {
        MODE_IMM,
        MODE_DIR,
        MODE_SDIR,
        MODE_EXT,
        MODE_REL,
        MODE_BSC,
        MODE_BTB,
        MODE_RIND
    } amd_mode_t;

    // Request for one instruction: mode, opcode, opcode address and branch condition.
    typedef struct packed {
        amd_mode_t mode;
        logic [7:0] opcode;
        logic [PC_W-1:0] pc;
        logic cond;
    } amd_req_t;

    // Result of one instruction.
    typedef struct packed {
        logic [PC_W-1:0] next_pc;
        logic [7:0] operand_location;
        logic [7:0] operand;
        logic carry_load;
        logic carry;
        logic taken;
    } amd_result_t;

    // Data-space access with one cycle of read latency.
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amd_dmem_t;

endpackage : amd_pkg

/* File: core/amd_target_adder.sv */
// Program-counter adder for fall-through and branch targets.
module amd_target_adder
    import amd_pkg::*;
(
    input wire logic [PC_W-1:0] base,
    input wire logic [1:0] len,
    input wire logic [PC_W-1:0] offset,
    input wire logic take,
    output logic [PC_W-1:0] next_pc
);

    // RULE_16: wrap modulo 4096.
    // The sum is kept at twelve bits, so a carry out of the top bit is lost.
    always_comb
    begin
        next_pc = base + {{(PC_W-2){1'b0}}, len} + (take ? offset : {PC_W{1'b0}});
    end

endmodule : amd_target_adder

/* File: core/amd_bit_unit.sv */
// Single-bit test and force logic for one data byte.
module amd_bit_unit
    import amd_pkg::*;
(
    input wire logic [7:0] byte_in,
    input wire logic [BIT_SEL_W-1:0] bit_sel,
    input wire logic force_one,
    output logic [7:0] modified,
    output logic tested
);

    // RULE_02: any bit examined.
    assign tested = byte_in[bit_sel];

    // RULE_01: force one bit only.
    // Each bit keeps its value unless it is the selected one.
    for (genvar i = 0; i < BYTE_W; i++)
    begin : g_bit
        assign modified[i] = (bit_sel == BIT_SEL_W'(i)) ? force_one : byte_in[i];
    end

endmodule : amd_bit_unit

/* File: core/amd_decoder.sv */
// Addressing-mode decoder: operand locations, operand fetch, bit ops and branch targets.
//
// Contract
// RULE_01: One bit-set or bit-clear instruction forces any one writable bit to one or zero.
// RULE_02: Bit-test-and-branch can examine any data-space bit, read-only ones included.
// RULE_03: Bit-test-and-branch loads the carry with the tested bit, taken or not.
// RULE_04: Program space, data space and stack space are kept apart.
// RULE_05: Immediate mode takes the operand from the program byte after the opcode.
// RULE_06: Direct mode uses the byte after the opcode as the data-space address.
// RULE_07: Short-direct mode selects $80 to $83 with the two low opcode bits in one byte.
// RULE_08: The first index register sits at $80 and the second at $81.
// RULE_09: Extended mode forms a 12-bit address from four opcode bits and the next byte.
// RULE_10: Relative branches add the sign-extended low five opcode bits only when taken.
// RULE_11: A relative target lies from 15 before to 16 after the opcode address.
// RULE_12: Bit set/clear takes the bit from the opcode and the address from the next byte.
// RULE_13: Bit-test-and-branch is three bytes and adds the sign-extended third byte.
// RULE_14: A bit-test-and-branch target lies from 125 before to 130 after the opcode.
// RULE_15: Register-indirect uses opcode bit 4 to pick the index register at $80 or $81.
// RULE_16: Branch-target sums wrap modulo 4096.
module amd_decoder
    import amd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire amd_req_t req,
    input wire logic prog_valid,
    output logic prog_ready,
    input wire logic [7:0] prog_byte,
    output amd_dmem_t dmem,
    input wire logic [7:0] dmem_rdata,
    output logic done,
    output amd_result_t result
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH1,
        ST_FETCH2,
        ST_RD,
        ST_CAP,
        ST_WR,
        ST_CALC,
        ST_DONE
    } amd_state_t;

    amd_state_t state_r, state_nxt;
    amd_mode_t mode_r, mode_nxt;
    logic [7:0] op_r, op_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic cond_r, cond_nxt;
    logic ind_r, ind_nxt;
    logic [7:0] byte1_r, byte1_nxt;
    logic [7:0] off_r, off_nxt;
    logic [7:0] loc_r, loc_nxt;
    logic [7:0] operand_r, operand_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic tested_r, tested_nxt;
    amd_result_t result_r, result_nxt;

    logic [7:0] bit_modified;
    logic bit_tested;
    logic [1:0] add_len;
    logic [PC_W-1:0] add_off;
    logic add_take;
    logic [PC_W-1:0] add_sum;

    // RULE_12: bit number from opcode.
    amd_bit_unit u_bit (
        .byte_in(dmem_rdata),
        .bit_sel(op_r[OP_BIT_LSB +: BIT_SEL_W]),
        .force_one(op_r[OP_POL_BIT]),
        .modified(bit_modified),
        .tested(bit_tested)
    );

    amd_target_adder u_add (
        .base(pc_r),
        .len(add_len),
        .offset(add_off),
        .take(add_take),
        .next_pc(add_sum)
    );

    // Adder operands per mode; lengths give the fall-through address.
    always_comb
    begin
        add_len = LEN_ONE;
        add_off = {PC_W{1'b0}};
        add_take = 1'b0;
        unique case (mode_r)
            MODE_REL:
            begin
                // RULE_10: sign-extended five-bit offset.
                // RULE_11: span from opcode plus one gives -15 to +16.
                add_off = {{(PC_W-OP_REL_MSB-1){op_r[OP_REL_MSB]}}, op_r[OP_REL_MSB:0]};
                add_take = cond_r;
            end
            MODE_BTB:
            begin
                // RULE_13: third byte extended to twelve bits.
                // RULE_14: three-byte base gives -125 to +130.
                add_len = LEN_THREE;
                add_off = {{(PC_W-BYTE_W){off_r[BYTE_W-1]}}, off_r};
                add_take = (tested_r == op_r[OP_POL_BIT]);
            end
            MODE_IMM, MODE_DIR, MODE_EXT, MODE_BSC: add_len = LEN_TWO;
            MODE_SDIR, MODE_RIND: add_len = LEN_ONE;
        endcase
    end

    // Handshakes toward the core and the fetch stream.
    assign req_ready = (state_r == ST_IDLE);
    assign prog_ready = (state_r == ST_FETCH1) || (state_r == ST_FETCH2);
    assign done = (state_r == ST_DONE);
    assign result = result_r;

    // RULE_04: data port carries only data-space accesses.
    // Program bytes arrive on their own stream and reach this address only as the location byte of direct, bit and bit-test modes.
    assign dmem.rd_en = (state_r == ST_RD);
    assign dmem.wr_en = (state_r == ST_WR);
    assign dmem.addr = loc_r;
    assign dmem.wdata = wdata_r;

    // Sequencer: fetch following bytes, read data space, write back, form the result.
    always_comb
    begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        op_nxt = op_r;
        pc_nxt = pc_r;
        cond_nxt = cond_r;
        ind_nxt = ind_r;
        byte1_nxt = byte1_r;
        off_nxt = off_r;
        loc_nxt = loc_r;
        operand_nxt = operand_r;
        wdata_nxt = wdata_r;
        tested_nxt = tested_r;
        result_nxt = result_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    mode_nxt = req.mode;
                    op_nxt = req.opcode;
                    pc_nxt = req.pc;
                    cond_nxt = req.cond;
                    ind_nxt = 1'b0;
                    loc_nxt = BYTE_RST;
                    tested_nxt = 1'b0;
                    unique case (req.mode)
                        MODE_SDIR:
                        begin
                            // RULE_07: two low opcode bits pick $80 to $83.
                            loc_nxt = SDIR_BASE | {6'h00, req.opcode[OP_SDIR_LSB +: 2]};
                            state_nxt = ST_RD;
                        end
                        MODE_RIND:
                        begin
                            // RULE_15: opcode bit 4 picks the index register.
                            // RULE_08: index registers at $80 and $81.
                            loc_nxt = IDX_BASE | {7'h00, req.opcode[OP_IDX_SEL_BIT]};
                            ind_nxt = 1'b1;
                            state_nxt = ST_RD;
                        end
                        MODE_REL: state_nxt = ST_CALC;
                        MODE_IMM, MODE_DIR, MODE_EXT, MODE_BSC, MODE_BTB:
                            state_nxt = ST_FETCH1;
                    endcase
                end
            end
            ST_FETCH1:
            begin
                if (prog_valid)
                begin
                    byte1_nxt = prog_byte;
                    unique case (mode_r)
                        MODE_IMM:
                        begin
                            // RULE_05: operand is the program byte itself.
                            operand_nxt = prog_byte;
                            state_nxt = ST_CALC;
                        end
                        MODE_EXT: state_nxt = ST_CALC;
                        MODE_BTB:
                        begin
                            loc_nxt = prog_byte;
                            state_nxt = ST_FETCH2;
                        end
                        default:
                        begin
                            // RULE_06: next byte is the data-space address.
                            loc_nxt = prog_byte;
                            state_nxt = ST_RD;
                        end
                    endcase
                end
            end
            ST_FETCH2:
            begin
                if (prog_valid)
                begin
                    off_nxt = prog_byte;
                    state_nxt = ST_RD;
                end
            end
            ST_RD: state_nxt = ST_CAP;
            ST_CAP:
            begin
                if (ind_r)
                begin
                    // The index register's contents become the operand location.
                    loc_nxt = dmem_rdata;
                    ind_nxt = 1'b0;
                    state_nxt = ST_RD;
                end
                else
                begin
                    operand_nxt = dmem_rdata;
                    tested_nxt = bit_tested;
                    wdata_nxt = bit_modified;
                    // RULE_12: only bit set/clear writes the modified byte back.
                    state_nxt = (mode_r == MODE_BSC) ? ST_WR : ST_CALC;
                end
            end
            ST_WR: state_nxt = ST_CALC;
            ST_CALC:
            begin
                // RULE_09: four opcode bits above the following byte.
                result_nxt.next_pc = (mode_r == MODE_EXT) ?
                    {op_r[OP_EXT_MSB:0], byte1_r} : add_sum;
                result_nxt.operand_location = loc_r;
                result_nxt.operand = (mode_r == MODE_BSC) ? wdata_r : operand_r;
                // RULE_03: carry takes the tested bit either way.
                result_nxt.carry_load = (mode_r == MODE_BTB);
                result_nxt.carry = tested_r;
                result_nxt.taken = add_take;
                state_nxt = ST_DONE;
            end
            ST_DONE: state_nxt = ST_IDLE;
        endcase
    end

    // State registers.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            mode_r <= MODE_IMM;
            op_r <= BYTE_RST;
            pc_r <= PC_RST;
            cond_r <= 1'b0;
            ind_r <= 1'b0;
            byte1_r <= BYTE_RST;
            off_r <= BYTE_RST;
            loc_r <= BYTE_RST;
            operand_r <= BYTE_RST;
            wdata_r <= BYTE_RST;
            tested_r <= 1'b0;
            result_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            op_r <= op_nxt;
            pc_r <= pc_nxt;
            cond_r <= cond_nxt;
            ind_r <= ind_nxt;
            byte1_r <= byte1_nxt;
            off_r <= off_nxt;
            loc_r <= loc_nxt;
            operand_r <= operand_nxt;
            wdata_r <= wdata_nxt;
            tested_r <= tested_nxt;
            result_r <= result_nxt;
        end
    end

    // Checks on the sequencer.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_index_read;
        state_r == ST_CAP && ind_r;
    endsequence

    sequence s_operand_read;
        state_r == ST_RD && !ind_r;
    endsequence

    a_sdir_location: assert property ( // RULE_07
        (req_valid && req_ready && req.mode == MODE_SDIR) |=>
            dmem.rd_en && dmem.addr == (8'h80 | {6'h00, $past(req.opcode[1:0])}))
        else $error("Short-direct location wrong.");

    a_index_select: assert property ( // RULE_15
        (req_valid && req_ready && req.mode == MODE_RIND) |=>
            dmem.rd_en && dmem.addr == (8'h80 | {7'h00, $past(req.opcode[4])}))
        else $error("Index register address wrong.");

    a_index_chain: assert property ( // RULE_08
        s_index_read |=> s_operand_read ##0 dmem.addr == $past(dmem_rdata))
        else $error("Index contents not used as location.");

    a_direct_location: assert property ( // RULE_06
        (state_r == ST_FETCH1 && prog_valid && mode_r == MODE_DIR) |=>
            dmem.rd_en && dmem.addr == $past(prog_byte))
        else $error("Direct location wrong.");

    a_imm_no_data: assert property ( // RULE_05
        (dmem.rd_en || dmem.wr_en) |-> (mode_r != MODE_IMM && mode_r != MODE_EXT))
        else $error("Immediate or extended touched data space.");

    a_ext_target: assert property ( // RULE_09
        (state_r == ST_FETCH1 && prog_valid && mode_r == MODE_EXT) |=> ##1
            done && result.next_pc == {$past(op_r[3:0], 2), $past(prog_byte, 2)})
        else $error("Extended target wrong.");

    a_rel_target: assert property ( // RULE_10
        (done && mode_r == MODE_REL) |-> result.next_pc == (cond_r ?
            12'(pc_r + 12'h001 + {{7{op_r[4]}}, op_r[4:0]}) : 12'(pc_r + 12'h001)))
        else $error("Relative target wrong.");

    a_btb_target: assert property ( // RULE_13
        (done && mode_r == MODE_BTB) |-> result.next_pc == (result.taken ?
            12'(pc_r + 12'h003 + {{4{off_r[7]}}, off_r}) : 12'(pc_r + 12'h003)))
        else $error("Bit-test branch target wrong.");

    a_btb_carry: assert property ( // RULE_03
        (state_r == ST_CAP && !ind_r && mode_r == MODE_BTB) |-> ##2
            done && result.carry_load && result.carry == $past(dmem_rdata[op_r[2:0]], 2))
        else $error("Carry not loaded with tested bit.");

    a_bit_write: assert property ( // RULE_01
        dmem.wr_en |-> wdata_r[op_r[2:0]] == op_r[3]
            && ((wdata_r ^ operand_r) & ~(8'h01 << op_r[2:0])) == 8'h00)
        else $error("Bit write changed the wrong bits.");

    a_done_single: assert property (
        done |=> !done && req_ready)
        else $error("Done held longer than one cycle.");

endmodule : amd_decoder

/* File: verif/tb_top.sv */
// Self-checking testbench of the addressing-mode decoder.
module tb_top
    import amd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [30:0] M_NOC = 31'h7ffffffd;
    localparam logic [30:0] M_NOOP = 31'h7ffff805;
    localparam logic [30:0] M_NOOPD = 31'h7ffff807;

    logic sys_clk;
    logic rst_n;
    logic req_valid;
    logic req_ready;
    amd_req_t req;
    logic prog_valid;
    logic prog_ready;
    logic [7:0] prog_byte;
    amd_dmem_t dmem;
    logic [7:0] dmem_rdata = 8'h00;
    logic done;
    amd_result_t result;
    int failures;
    int comparisons;
    int rd_cnt = 0;
    int wr_cnt = 0;
    int rd_base = 0;
    int wr_base = 0;
    logic rd_pend = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] mem [0:255];

    amd_decoder dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req_valid(req_valid),
        .req_ready(req_ready),
        .req(req),
        .prog_valid(prog_valid),
        .prog_ready(prog_ready),
        .prog_byte(prog_byte),
        .dmem(dmem),
        .dmem_rdata(dmem_rdata),
        .done(done),
        .result(result)
    );

    // The clock toggles every half period of 5 ns.
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Data-space model: writes land on the edge and reads are noted for the next cycle.
    always @(posedge sys_clk)
    begin
        rd_pend = dmem.rd_en;
        rd_addr = dmem.addr;
        if (dmem.rd_en === 1'b1)
            rd_cnt = rd_cnt + 1;
        if (dmem.wr_en === 1'b1)
        begin
            mem[dmem.addr] = dmem.wdata;
            wr_cnt = wr_cnt + 1;
        end
    end

    // Read data appears one cycle after the read; otherwise the bus shows a toggling pattern.
    always @(negedge sys_clk)
        dmem_rdata <= (rd_pend === 1'b1) ? mem[rd_addr] : ~dmem_rdata;

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    // Compares one value with its expectation and reports a difference.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // Compares a result with its expectation over the fields named by the mask.
    task automatic check_res(input amd_result_t r, input amd_result_t e, input logic [30:0] m);
        check(32'(r & m), 32'(e & m));
    endtask : check_res

    // Builds an expected result; flags are carry_load, carry and taken.
    function automatic amd_result_t exp_r(input logic [11:0] npc, input logic [7:0] loc,
                                          input logic [7:0] opd, input logic [2:0] flg);
        return '{next_pc: npc, operand_location: loc, operand: opd,
                 carry_load: flg[2], carry: flg[1], taken: flg[0]};
    endfunction : exp_r

    // Issues one instruction, feeds its program bytes after a stall and waits for done.
    task automatic run(input amd_mode_t mode, input logic [7:0] op, input logic [11:0] pc,
                       input logic cond, input logic [7:0] b2, input logic [7:0] b3,
                       input int stall, output amd_result_t r);
        int idx;
        int n;
        idx = 0;
        // The model owns the access counters; each instruction is judged by their growth.
        rd_base = rd_cnt;
        wr_base = wr_cnt;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = '{mode: mode, opcode: op, pc: pc, cond: cond};
        n = 0;
        while (req_ready !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (req_ready !== 1'b1)
        begin
            failures++;
            final_report();
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        req.opcode = ~op;
        for (n = 0; n < 30; n++)
        begin
            if (done === 1'b1)
                break;
            prog_valid = (n >= stall) && (idx < 2);
            prog_byte = prog_valid ? ((idx == 0) ? b2 : b3) : ~prog_byte;
            if (prog_valid && prog_ready === 1'b1)
                idx++;
            @(negedge sys_clk);
        end
        prog_valid = 1'b0;
        if (done !== 1'b1)
        begin
            failures++;
            final_report();
        end
        r = result;
    endtask : run

    // Immediate operand comes from the program stream without any data read.
    task automatic t_imm();
        amd_result_t r;
        mem[8'h5a] = 8'h11;
        run(MODE_IMM, 8'ha8, 12'h100, 1'b0, 8'h5a, 8'h00, 2, r);
        check_res(r, exp_r(12'h102, 8'h00, 8'h5a, 3'h0), M_NOC);
        check(32'(rd_cnt - rd_base), 32'h0);
    endtask : t_imm

    // Direct addresses at both ends of data space, with program stalls.
    task automatic t_dir();
        amd_result_t r;
        logic [7:0] a;
        for (int i = 0; i < 3; i++)
        begin
            a = (i == 0) ? 8'h00 : ((i == 1) ? 8'h7f : 8'hff);
            mem[a] = a ^ 8'h96;
            run(MODE_DIR, 8'hb0, 12'hffe, 1'b0, a, 8'h00, i, r);
            check_res(r, exp_r(12'h000, a, a ^ 8'h96, 3'h0), M_NOC);
        end
    endtask : t_dir

    // Each of the four short-direct locations.
    task automatic t_sdir();
        amd_result_t r;
        for (int k = 0; k < 4; k++)
        begin
            mem[8'h80 + 8'(k)] = 8'h40 + 8'(k);
            run(MODE_SDIR, {6'h2b, 2'(k)}, 12'h200, 1'b0, 8'hc3, 8'h00, 0, r);
            check_res(r, exp_r(12'h201, 8'h80 + 8'(k), 8'h40 + 8'(k), 3'h0), M_NOC);
        end
    endtask : t_sdir

    // Both index registers select the operand through their contents.
    task automatic t_rind();
        amd_result_t r;
        mem[8'h80] = 8'h21;
        mem[8'h81] = 8'h37;
        mem[8'h21] = 8'h5c;
        mem[8'h37] = 8'ha3;
        run(MODE_RIND, 8'he0, 12'h300, 1'b0, 8'h00, 8'h00, 0, r);
        check_res(r, exp_r(12'h301, 8'h21, 8'h5c, 3'h0), M_NOC);
        run(MODE_RIND, 8'hf0, 12'h300, 1'b0, 8'h00, 8'h00, 0, r);
        check_res(r, exp_r(12'h301, 8'h37, 8'ha3, 3'h0), M_NOC);
    endtask : t_rind

    // Extended targets built from the opcode nibble and the next byte.
    task automatic t_ext();
        amd_result_t r;
        run(MODE_EXT, 8'h9a, 12'h050, 1'b0, 8'h34, 8'h00, 1, r);
        check_res(r, exp_r(12'ha34, 8'h00, 8'h00, 3'h0), M_NOOP);
        run(MODE_EXT, 8'h9f, 12'hfff, 1'b0, 8'hff, 8'h00, 0, r);
        check_res(r, exp_r(12'hfff, 8'h00, 8'h00, 3'h0), M_NOOP);
    endtask : t_ext

    // Relative branches at both span limits, not taken, and across the wrap.
    task automatic t_rel();
        amd_result_t r;
        logic [4:0] o;
        logic c;
        logic [11:0] pc;
        logic [11:0] npc;
        for (int i = 0; i < 5; i++)
        begin
            o = (i == 0 || i == 3) ? 5'h10 : ((i == 4) ? 5'h1f : 5'h0f);
            c = (i != 2);
            pc = (i == 3) ? 12'h000 : ((i == 4) ? 12'hfff : 12'h400);
            npc = pc + 12'h001 + (c ? {{7{o[4]}}, o} : 12'h000);
            run(MODE_REL, {3'h5, o}, pc, c, 8'h00, 8'h00, 0, r);
            check_res(r, exp_r(npc, 8'h00, 8'h00, {2'h0, c}), M_NOOP);
        end
    endtask : t_rel

    // Bit force to one and to zero, including a bit already in its target state.
    task automatic t_bsc();
        amd_result_t r;
        logic p;
        logic [2:0] b;
        logic [7:0] a;
        logic [7:0] v;
        logic [7:0] m;
        for (int i = 0; i < 3; i++)
        begin
            p = (i != 1);
            b = (i == 0) ? 3'h7 : ((i == 1) ? 3'h0 : 3'h3);
            a = (i == 0) ? 8'h82 : ((i == 1) ? 8'h10 : 8'hff);
            v = (i == 0) ? 8'h00 : ((i == 1) ? 8'hff : 8'h08);
            mem[a] = v;
            m = p ? (v | (8'h01 << b)) : (v & ~(8'h01 << b));
            run(MODE_BSC, {4'h1, p, b}, 12'h600, 1'b0, a, 8'h00, i, r);
            check_res(r, exp_r(12'h602, a, m, 3'h0), M_NOC);
            check(32'(mem[a]), 32'(m));
            check(32'(wr_cnt - wr_base), 32'h1);
        end
    endtask : t_bsc

    // Bit test and branch in both polarities, both span limits and across the wrap.
    task automatic t_btb();
        amd_result_t r;
        logic p;
        logic [2:0] b;
        logic [7:0] v;
        logic [7:0] o;
        logic [11:0] pc;
        logic t;
        logic tk;
        for (int i = 0; i < 5; i++)
        begin
            p = (i == 0 || i >= 3);
            b = (i < 2) ? 3'h5 : ((i == 4) ? 3'h0 : 3'h2);
            v = (i < 2) ? 8'h20 : ((i == 4) ? 8'h01 : 8'hfb);
            o = (i == 0 || i == 3) ? 8'h80 : 8'h7f;
            pc = (i == 4) ? 12'hffe : 12'h500;
            t = v[b];
            tk = (t == p);
            mem[8'hc0] = v;
            run(MODE_BTB, {4'h2, p, b}, pc, 1'b0, 8'hc0, o, i, r);
            check_res(r, exp_r(pc + 12'h003 + (tk ? {{4{o[7]}}, o} : 12'h000), 8'hc0, 8'h00,
                               {1'b1, t, tk}), M_NOOPD);
            check(32'(wr_cnt - wr_base), 32'h0);
        end
    endtask : t_btb

    // Main sequence: reset for four cycles, then every scenario in turn.
    initial
    begin
        failures = 0;
        comparisons = 0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        prog_valid = 1'b0;
        prog_byte = 8'h00;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        t_imm();
        t_dir();
        t_sdir();
        t_rind();
        t_ext();
        t_rel();
        t_bsc();
        t_btb();
        final_report();
    end

endmodule : tb_top
